/* File: pkg/asrb_pkg.sv */
// Constants of the audio serial register bank: offsets, masks, resets, timing
package asrb_pkg;
    // ==========================================================
    // Register byte offsets
    localparam logic [5:0] OFS_MAIN_CONTROL = 6'h00;
    localparam logic [5:0] OFS_CLOCK_UNIT0 = 6'h04;
    localparam logic [5:0] OFS_CLOCK_UNIT1 = 6'h08;
    localparam logic [5:0] OFS_IRQ_ENABLE_CLEAR = 6'h0c;
    localparam logic [5:0] OFS_IRQ_ENABLE_SET = 6'h10;
    localparam logic [5:0] OFS_IRQ_FLAGS = 6'h14;
    localparam logic [5:0] OFS_SYNC_BUSY = 6'h18;
    localparam logic [5:0] OFS_SERIALIZER0 = 6'h20;
    localparam logic [5:0] OFS_SERIALIZER1 = 6'h24;
    localparam logic [5:0] OFS_HOLDING0 = 6'h30;
    localparam logic [5:0] OFS_HOLDING1 = 6'h34;
    localparam logic [5:0] OFS_WORD_MASK = 6'h3c;
    // ==========================================================
    // Reset values
    localparam logic [7:0] RST_MAIN_CONTROL = 8'h00;
    localparam logic [31:0] RST_CLOCK_UNIT = 32'h0000_0000;
    localparam logic [31:0] RST_SERIALIZER = 32'h0000_0000;
    localparam logic [31:0] RST_HOLDING = 32'h0000_0000;
    localparam logic [15:0] RST_IRQ = 16'h0000;
    // ==========================================================
    // Writable bit masks; reserved bits stay zero
    localparam logic [7:0] MASK_MAIN_CONTROL = 8'h3f;
    localparam logic [31:0] MASK_CLOCK_UNIT = 32'hfffd_19ff;
    localparam logic [31:0] MASK_SERIALIZER = 32'h07ff_f7bf;
    localparam logic [31:0] MASK_HOLDING = 32'hffff_ffff;
    localparam logic [15:0] MASK_IRQ = 16'h3333;
    // ==========================================================
    // Main control and sync busy bit positions
    localparam int BIT_SOFT_RESET = 0;
    localparam int BIT_MODULE_ON = 1;
    localparam int BIT_CLOCK_UNIT_ON = 2;
    localparam int BIT_SERIALIZER_ON = 4;
    localparam int BIT_CTRL_TOP = 5;
    localparam int BIT_BUSY_HOLDING = 8;
    // ==========================================================
    // Serializer mode field and its receive code
    localparam int SER_MODE_LSB = 0;
    localparam logic [1:0] SER_MODE_RX = 2'h0;
    // ==========================================================
    // Cycles to carry a value into the audio clock domain
    localparam int SYNC_CYCLES = 4;
    // Avalon response codes
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLAVE_ERROR = 2'h2;
endpackage

/* File: pkg/asrb_lane_if.sv */
// Write lanes and data shared by all plain registers of the bank
`timescale 1ns/100ps
interface asrb_lane_if;
    logic [3:0] be;
    logic [31:0] wdata;
    modport src (output be, output wdata);
    modport dst (input be, input wdata);
endinterface

/* File: rtl/asrb_sync_track.sv */
// Busy tracker for one value carried into the audio clock domain
`timescale 1ns/100ps
module asrb_sync_track #(
    parameter int CYCLES = 4
) (
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic start_in,
    output logic busy_out,
    output logic done_out
);
    localparam int CW = $clog2(CYCLES + 1);
    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;

    // Busy from start until the value lands; done marks the last cycle
    assign busy_out = (cnt_q != '0);
    assign done_out = (cnt_q == CW'(1));
    assign cnt_d = start_in ? CW'(CYCLES) : (busy_out ? cnt_q - CW'(1) : cnt_q);

    // Only hard reset: a soft reset in flight is itself tracked here
    always_ff @(posedge mclk_in) begin
        if (rst_in) cnt_q <= '0;
        else cnt_q <= cnt_d;
    end
endmodule // asrb_sync_track

/* File: rtl/asrb_lane_reg.sv */
// One register written byte lane by byte lane
`timescale 1ns/100ps
module asrb_lane_reg #(
    parameter int W = 32,
    parameter logic [31:0] MASK = 32'hffff_ffff,
    parameter logic [31:0] RESET = 32'h0000_0000
) (
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic wr_en_in,
    asrb_lane_if.dst bus,
    output logic [W-1:0] value_out
);
    // Each lane stands alone, so byte and halfword writes keep the rest
    for (genvar b = 0; b < W / 8; b++) begin : g_lane
        always_ff @(posedge mclk_in) begin
            if (rst_in) begin
                value_out[b*8 +: 8] <= RESET[b*8 +: 8];
            end else if (wr_en_in && bus.be[b]) begin
                value_out[b*8 +: 8] <= bus.wdata[b*8 +: 8] & MASK[b*8 +: 8];
            end
        end
    end
endmodule // asrb_lane_reg

/* File: rtl/asrb_register_bank.sv */
// Register bank of the two-serializer audio serial interface, Avalon-MM slave
// Notes on behaviour
// - Byte, halfword and word accesses are accepted.
// - Each byte lane written alone, others kept.
// - Protected setup writes only while module disabled.
// - Locked peripheral ignores writes to main control and clock units, not to serializers.
// - Synced writes show busy until transfer completes.
// - Main control resets zero, protected, synchronized.
// - Bits 5:4 switch serializers on and off.
// - Reserved control bits read zero; software writes zero.
// - Synced access while busy gives bus error.
// - Soft reset restores all registers, disables module.
// - Soft reset write discards its other bits.
// - Enable bits switch module and clock units.
`timescale 1ns/100ps
module asrb_register_bank #(
    parameter int SYNC_CYCLES = asrb_pkg::SYNC_CYCLES
) (
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic [5:0] avs_address_in,
    input wire logic [3:0] avs_byteenable_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    output logic [1:0] avs_response_out,
    input wire logic wp_lock_in,
    input wire logic [15:0] irq_event_in,
    output logic module_on_out,
    output logic [1:0] clock_unit_on_out,
    output logic [1:0] serializer_on_out,
    output logic [1:0][31:0] clock_unit_config_out,
    output logic [1:0][31:0] serializer_config_out,
    output logic [1:0][31:0] serializer_holding_out,
    output logic [1:0] holding_update_out,
    output logic [15:0] irq_enable_out,
    output logic [15:0] irq_flags_out
);
    localparam int CT = asrb_pkg::BIT_CTRL_TOP;
    localparam int HB = asrb_pkg::BIT_BUSY_HOLDING;

    // ==========================================================
    // Bus handshake
    logic ack_q;
    logic [31:0] rdata_q;
    wire req = avs_read_in | avs_write_in;
    wire take = req & ack_q;
    wire wr_take = take & avs_write_in;
    wire rd_take = take & avs_read_in;
    wire [5:0] word = avs_address_in & asrb_pkg::OFS_WORD_MASK;
    wire [3:0] be = avs_byteenable_in;
    wire [31:0] wd = avs_writedata_in;

    // One wait cycle for every access; the answer stands in the next cycle
    assign avs_waitrequest_out = req & ~ack_q;

    always_ff @(posedge mclk_in) begin
        if (rst_in) ack_q <= 1'b0;
        else ack_q <= req & ~ack_q;
    end

    // ==========================================================
    // Address decode
    wire hit_ctrl = (word == asrb_pkg::OFS_MAIN_CONTROL);
    wire hit_clk0 = (word == asrb_pkg::OFS_CLOCK_UNIT0);
    wire hit_clk1 = (word == asrb_pkg::OFS_CLOCK_UNIT1);
    wire hit_iec = (word == asrb_pkg::OFS_IRQ_ENABLE_CLEAR);
    wire hit_ies = (word == asrb_pkg::OFS_IRQ_ENABLE_SET);
    wire hit_ifl = (word == asrb_pkg::OFS_IRQ_FLAGS);
    wire hit_busy = (word == asrb_pkg::OFS_SYNC_BUSY);
    wire hit_ser0 = (word == asrb_pkg::OFS_SERIALIZER0);
    wire hit_ser1 = (word == asrb_pkg::OFS_SERIALIZER1);
    wire hit_hold0 = (word == asrb_pkg::OFS_HOLDING0);
    wire hit_hold1 = (word == asrb_pkg::OFS_HOLDING1);
    wire [1:0] hit_clk = {hit_clk1, hit_clk0};
    wire [1:0] hit_ser = {hit_ser1, hit_ser0};
    wire [1:0] hit_hold = {hit_hold1, hit_hold0};

    // ==========================================================
    // Synchronization trackers for busy bits 5:0 and 9:8; the other busy bits tie to zero
    wire [15:0] busy;
    wire [15:0] done;
    wire [15:0] sync_start;

    for (genvar i = 0; i < HB + 2; i++) begin : g_sync
        if (i <= CT || i >= HB) begin : g_bit
            asrb_sync_track #(
                .CYCLES(SYNC_CYCLES)
            ) u_track (
                .mclk_in(mclk_in),
                .rst_in(rst_in),
                .start_in(sync_start[i]),
                .busy_out(busy[i]),
                .done_out(done[i])
            );
        end else begin : g_none
            assign busy[i] = 1'b0;
            assign done[i] = 1'b0;
        end
    end
    assign busy[15:HB+2] = '0;
    assign done[15:HB+2] = '0;

    // ==========================================================
    // Soft reset lands when its own transfer completes
    wire soft_rst = done[asrb_pkg::BIT_SOFT_RESET];
    wire any_rst = rst_in | soft_rst;

    // ==========================================================
    // Main control
    logic [CT:1] ctrl_q;
    logic [CT:1] on_q;
    wire [1:0] ser_mode [2];
    wire [1:0] ser_rx;
    wire module_locked = ctrl_q[asrb_pkg::BIT_MODULE_ON] | on_q[asrb_pkg::BIT_MODULE_ON];

    // Any control bit in flight blocks the next control write
    wire err_ctrl = wr_take & hit_ctrl & be[0] & (|busy[CT:0]);
    wire wr_ctrl = wr_take & hit_ctrl & be[0] & ~wp_lock_in & ~err_ctrl;
    wire soft_reset_wr = wr_ctrl & wd[asrb_pkg::BIT_SOFT_RESET];

    // Soft reset starts only its own transfer, everything else dropped
    wire [CT:0] ctrl_start = soft_reset_wr ? (CT+1)'(1) :
        (wr_ctrl ? {{CT{1'b1}}, 1'b0} : '0);

    // Requested state is kept on the bus side; reads return it at once
    always_ff @(posedge mclk_in) begin
        if (any_rst) ctrl_q <= asrb_pkg::RST_MAIN_CONTROL[CT:1];
        else if (wr_ctrl && !soft_reset_wr) ctrl_q <= wd[CT:1] & asrb_pkg::MASK_MAIN_CONTROL[CT:1];
    end

    // Each enable takes effect in the audio domain when its transfer is done
    for (genvar k = 1; k <= CT; k++) begin : g_on
        always_ff @(posedge mclk_in) begin
            if (any_rst) on_q[k] <= 1'b0;
            else if (done[k]) on_q[k] <= ctrl_q[k];
        end
    end

    assign module_on_out = on_q[asrb_pkg::BIT_MODULE_ON];
    assign clock_unit_on_out = on_q[asrb_pkg::BIT_CLOCK_UNIT_ON +: 2];
    assign serializer_on_out = on_q[asrb_pkg::BIT_SERIALIZER_ON +: 2];

    // Bits 7:6 never stored and read back as zero; bit 0 shows reset ongoing
    wire [7:0] ctrl_rd = {2'h0, ctrl_q, busy[asrb_pkg::BIT_SOFT_RESET]};

    // ==========================================================
    // Plain lane registers: clock units, serializers, holding words
    asrb_lane_if lanes ();
    assign lanes.be = be;
    assign lanes.wdata = wd;

    wire [1:0] wr_clk;
    wire [1:0] wr_ser;
    wire [1:0] wr_hold;
    wire [1:0] err_hold;
    wire [1:0] hold_start;

    for (genvar m = 0; m < 2; m++) begin : g_unit
        assign ser_mode[m] = serializer_config_out[m][asrb_pkg::SER_MODE_LSB +: 2];
        assign ser_rx[m] = (ser_mode[m] == asrb_pkg::SER_MODE_RX);

        // Setup registers are frozen while the module is on
        assign wr_clk[m] = wr_take & hit_clk[m] & ~wp_lock_in & ~module_locked;
        assign wr_ser[m] = wr_take & hit_ser[m] & ~module_locked;

        // Holding words are write-synced when sending, read-synced when receiving
        assign err_hold[m] = take & hit_hold[m] & busy[HB+m] &
            ((avs_write_in & ~ser_rx[m]) | (avs_read_in & ser_rx[m]));
        assign wr_hold[m] = wr_take & hit_hold[m] & ~err_hold[m];
        assign hold_start[m] = ~err_hold[m] & hit_hold[m] &
            ((wr_take & ~ser_rx[m]) | (rd_take & ser_rx[m]));

        asrb_lane_reg #(
            .W(32),
            .MASK(asrb_pkg::MASK_CLOCK_UNIT),
            .RESET(asrb_pkg::RST_CLOCK_UNIT)
        ) u_clk (
            .mclk_in(mclk_in),
            .rst_in(any_rst),
            .wr_en_in(wr_clk[m]),
            .bus(lanes),
            .value_out(clock_unit_config_out[m])
        );

        asrb_lane_reg #(
            .W(32),
            .MASK(asrb_pkg::MASK_SERIALIZER),
            .RESET(asrb_pkg::RST_SERIALIZER)
        ) u_ser (
            .mclk_in(mclk_in),
            .rst_in(any_rst),
            .wr_en_in(wr_ser[m]),
            .bus(lanes),
            .value_out(serializer_config_out[m])
        );

        asrb_lane_reg #(
            .W(32),
            .MASK(asrb_pkg::MASK_HOLDING),
            .RESET(asrb_pkg::RST_HOLDING)
        ) u_hold (
            .mclk_in(mclk_in),
            .rst_in(any_rst),
            .wr_en_in(wr_hold[m]),
            .bus(lanes),
            .value_out(serializer_holding_out[m])
        );

        // The serializer picks up the word when the transfer is done
        assign holding_update_out[m] = done[HB+m];
    end

    assign sync_start = {{(15-HB-1){1'b0}}, hold_start, {(HB-CT-1){1'b0}}, ctrl_start};

    // ==========================================================
    // Interrupt enables and flags, sixteen bits in two lanes
    logic [15:0] ien_q;
    logic [15:0] iflag_q;
    wire [15:0] lane16 = {{8{be[1]}}, {8{be[0]}}};
    wire [15:0] wbits = wd[15:0] & lane16 & asrb_pkg::MASK_IRQ;
    wire [15:0] ien_set = (wr_take & hit_ies) ? wbits : '0;
    wire [15:0] ien_clr = (wr_take & hit_iec) ? wbits : '0;
    wire [15:0] flag_clr = (wr_take & hit_ifl) ? wbits : '0;
    wire [15:0] flag_set = irq_event_in & asrb_pkg::MASK_IRQ;

    // Enable set and clear by writing ones
    always_ff @(posedge mclk_in) begin
        if (any_rst) ien_q <= asrb_pkg::RST_IRQ;
        else ien_q <= (ien_q & ~ien_clr) | ien_set;
    end

    // A condition arriving with a clear wins, so no event is lost
    always_ff @(posedge mclk_in) begin
        if (any_rst) iflag_q <= asrb_pkg::RST_IRQ;
        else iflag_q <= (iflag_q & ~flag_clr) | flag_set;
    end

    assign irq_enable_out = ien_q;
    assign irq_flags_out = iflag_q;

    // ==========================================================
    // Read mux; anything not decoded reads zero without error
    wire [31:0] rdata_d =
        ({32{hit_ctrl}} & {24'h0, ctrl_rd}) |
        ({32{hit_clk0}} & clock_unit_config_out[0]) |
        ({32{hit_clk1}} & clock_unit_config_out[1]) |
        ({32{hit_iec | hit_ies}} & {16'h0, ien_q}) |
        ({32{hit_ifl}} & {16'h0, iflag_q}) |
        ({32{hit_busy}} & {16'h0, busy}) |
        ({32{hit_ser0}} & serializer_config_out[0]) |
        ({32{hit_ser1}} & serializer_config_out[1]) |
        ({32{hit_hold0}} & serializer_holding_out[0]) |
        ({32{hit_hold1}} & serializer_holding_out[1]);

    // Word is loaded in the wait cycle and stands while the master samples
    always_ff @(posedge mclk_in) begin
        if (rst_in) rdata_q <= '0;
        else if (avs_read_in && !ack_q) rdata_q <= rdata_d;
    end
    assign avs_readdata_out = rdata_q;

    // Error answer is combinational so it matches the busy state at sampling
    wire bus_err = err_ctrl | (|err_hold);
    assign avs_response_out = (take & bus_err) ?
        asrb_pkg::RESP_SLAVE_ERROR : asrb_pkg::RESP_OKAY;
endmodule // asrb_register_bank

/* File: tb/asrb_register_bank_assertions.sv */
// Concurrent checks on the ports of the audio serial register bank
`timescale 1ns/100ps
module asrb_register_bank_assertions #(
    parameter int SYNC_CYCLES = asrb_pkg::SYNC_CYCLES
) (
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic [5:0] avs_address_in,
    input wire logic [3:0] avs_byteenable_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [31:0] avs_readdata_out,
    input wire logic avs_waitrequest_out,
    input wire logic [1:0] avs_response_out,
    input wire logic wp_lock_in,
    input wire logic [15:0] irq_event_in,
    input wire logic module_on_out,
    input wire logic [1:0] clock_unit_on_out,
    input wire logic [1:0] serializer_on_out,
    input wire logic [1:0][31:0] clock_unit_config_out,
    input wire logic [1:0][31:0] serializer_config_out,
    input wire logic [1:0] holding_update_out,
    input wire logic [15:0] irq_enable_out,
    input wire logic [15:0] irq_flags_out
);
    // Enables land one edge after the last busy cycle
    localparam int D = SYNC_CYCLES + 1;
    // ========
    // Accepted transfers; a locked or refused control write changes nothing
    wire logic rq = avs_read_in || avs_write_in;
    wire logic tk = rq && !avs_waitrequest_out;
    wire logic rd_tk = tk && avs_read_in;
    wire logic ctrl_tk = tk && avs_write_in && avs_address_in[5:2] == 4'h0
        && avs_byteenable_in[0] && !wp_lock_in && avs_response_out == asrb_pkg::RESP_OKAY;
    wire logic [15:0] ev = irq_event_in & asrb_pkg::MASK_IRQ;
    // Holding word 0 access that starts a sync: read when receiving, write when sending
    wire logic hold0_rx = serializer_config_out[0][1:0] == asrb_pkg::SER_MODE_RX;
    wire logic hold0_tk = tk && avs_address_in[5:2] == 4'hc
        && avs_response_out == asrb_pkg::RESP_OKAY && (avs_read_in == hold0_rx);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (rst_in);
    // ========
    // Assertions
    AST_ONE_WAIT: assert property (rq && avs_waitrequest_out |=> !avs_waitrequest_out)
        else $error("request not answered after one wait cycle");
    AST_RESP_IDLE: assert property (!tk |-> avs_response_out == asrb_pkg::RESP_OKAY)
        else $error("response code outside an answer cycle");
    AST_CTRL_RSVD: assert property (rd_tk && avs_address_in[5:2] == 4'h0
        |-> avs_readdata_out[31:6] == 26'h0)
        else $error("reserved control bits read nonzero");
    AST_UNMAPPED: assert property (rd_tk
        && avs_address_in[5:2] inside {4'h7, 4'ha, 4'hb, 4'he, 4'hf}
        |-> avs_readdata_out == 32'h0 && avs_response_out == asrb_pkg::RESP_OKAY)
        else $error("unmapped offset read nonzero or refused");
    AST_LOCK: assert property (tk && avs_write_in && wp_lock_in
        && avs_address_in == 6'h04 |=> $stable(clock_unit_config_out[0]))
        else $error("locked clock unit config changed");
    AST_ENPROT: assert property (tk && avs_write_in && module_on_out
        && avs_address_in == 6'h20 |=> $stable(serializer_config_out[0]))
        else $error("serializer config changed while enabled");
    AST_EN_DELAY: assert property (
        $changed({module_on_out, clock_unit_on_out, serializer_on_out}) |-> $past(ctrl_tk, D))
        else $error("enable output changed without a synced control write");
    AST_SOFT: assert property (ctrl_tk && avs_writedata_in[0] |-> ##D (!module_on_out
        && clock_unit_on_out == 2'h0 && serializer_on_out == 2'h0 && irq_enable_out == 16'h0))
        else $error("soft reset left something enabled");
    AST_IRQ_SET: assert property (ev != 16'h0
        |=> (irq_flags_out & $past(ev)) == $past(ev))
        else $error("event did not set its flag");
    // The serializer sees the word in the last busy cycle of its transfer
    AST_HOLD_UPD: assert property (hold0_tk |-> ##SYNC_CYCLES holding_update_out[0])
        else $error("holding word transfer gave no update pulse");
    // Main scenarios reached
    cover property (ctrl_tk && avs_writedata_in[0]);
    cover property (tk && avs_response_out == asrb_pkg::RESP_SLAVE_ERROR);
    cover property ($rose(module_on_out));
endmodule // asrb_register_bank_assertions

/* File: tb/asrb_register_bank_test.sv */
// Directed bus-level testbench of the audio serial register bank
`timescale 1ns/100ps
module asrb_register_bank_test;
    localparam int SYNC = asrb_pkg::SYNC_CYCLES;
    logic mclk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [5:0] avs_address_in = 6'h00;
    logic [3:0] avs_byteenable_in = 4'h0;
    logic avs_read_in = 1'b0;
    logic avs_write_in = 1'b0;
    logic [31:0] avs_writedata_in = 32'h0;
    logic wp_lock_in = 1'b0;
    logic [15:0] irq_event_in = 16'h0;
    logic [31:0] avs_readdata_out;
    logic avs_waitrequest_out;
    logic [1:0] avs_response_out;
    logic module_on_out;
    logic [1:0] clock_unit_on_out, serializer_on_out, holding_update_out;
    logic [1:0][31:0] clock_unit_config_out, serializer_config_out, serializer_holding_out;
    logic [15:0] irq_enable_out, irq_flags_out;
    int n_errors = 0;
    int compares = 0;
    logic [31:0] q;
    logic [1:0] r;
    logic [5:0] ofs [14] = '{6'h00, 6'h04, 6'h08, 6'h0c, 6'h10, 6'h14, 6'h18,
        6'h20, 6'h24, 6'h30, 6'h34, 6'h1c, 6'h28, 6'h3c};
    // 250 MHz clock
    always #2 mclk_in = ~mclk_in;
    asrb_register_bank #(.SYNC_CYCLES(SYNC)) u_asrb_register_bank (.mclk_in, .rst_in,
        .avs_address_in, .avs_byteenable_in, .avs_read_in, .avs_write_in, .avs_writedata_in,
        .avs_readdata_out, .avs_waitrequest_out, .avs_response_out, .wp_lock_in,
        .irq_event_in, .module_on_out, .clock_unit_on_out, .serializer_on_out,
        .clock_unit_config_out, .serializer_config_out, .serializer_holding_out,
        .holding_update_out, .irq_enable_out, .irq_flags_out);
    // ========
    // Verdict and comparisons
    task automatic give_verdict();
        $display("compares=%0d n_errors=%0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chkr(input logic [1:0] got, input logic [1:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD response at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One Avalon transfer; held until waitrequest is seen low, then a free cycle
    task automatic acc(input logic wr, input logic [5:0] a, input logic [3:0] be,
        input logic [31:0] d);
        int n;
        n = 0;
        avs_address_in <= a;
        avs_byteenable_in <= be;
        avs_writedata_in <= d;
        avs_write_in <= wr;
        avs_read_in <= !wr;
        @(posedge mclk_in);
        while (avs_waitrequest_out !== 1'b0) begin
            n++;
            if (n > 20) begin
                n_errors++;
                give_verdict();
            end
            @(posedge mclk_in);
        end
        q = avs_readdata_out;
        r = avs_response_out;
        avs_write_in <= 1'b0;
        avs_read_in <= 1'b0;
        @(posedge mclk_in);
    endtask
    task automatic wr(input logic [5:0] a, input logic [3:0] be, input logic [31:0] d,
        input logic [1:0] er);
        acc(1'b1, a, be, d);
        chkr(r, er);
    endtask
    task automatic rd(input logic [5:0] a, input logic [31:0] exp);
        acc(1'b0, a, 4'hf, 32'h0);
        chkr(r, asrb_pkg::RESP_OKAY);
        chk(q, exp);
    endtask
    // Poll the busy register with a bound, so a stuck transfer cannot hang the run
    task automatic idle();
        int i;
        i = 0;
        do begin
            acc(1'b0, 6'h18, 4'hf, 32'h0);
            i++;
        end while (q !== 32'h0 && i < 20);
        if (q !== 32'h0) begin
            n_errors++;
            give_verdict();
        end
    endtask
    // ========
    // Main sequence
    initial begin
        repeat (12) @(posedge mclk_in);
        rst_in <= 1'b0;
        @(posedge mclk_in);
        foreach (ofs[i]) rd(ofs[i], 32'h0);
        wr(6'h1c, 4'hf, 32'hffff_ffff, asrb_pkg::RESP_OKAY);
        rd(6'h1c, 32'h0);
        // Byte and halfword lanes leave the other bytes alone
        wr(6'h30, 4'hf, 32'h1122_3344, asrb_pkg::RESP_OKAY);
        wr(6'h30, 4'h2, 32'haabb_ccdd, asrb_pkg::RESP_OKAY);
        wr(6'h30, 4'hc, 32'h5566_7788, asrb_pkg::RESP_OKAY);
        rd(6'h30, 32'h5566_cc44);
        chk(serializer_holding_out[0], 32'h5566_cc44);
        wr(6'h10, 4'h3, 32'h0000_ffff, asrb_pkg::RESP_OKAY);
        wr(6'h0c, 4'h2, 32'h0000_0100, asrb_pkg::RESP_OKAY);
        rd(6'h0c, 32'h0000_3233);
        chk({16'h0, irq_enable_out}, 32'h0000_3233);
        irq_event_in <= 16'hffff;
        @(posedge mclk_in);
        irq_event_in <= 16'h0000;
        rd(6'h14, 32'h0000_3333);
        wr(6'h14, 4'h1, 32'h0000_0011, asrb_pkg::RESP_OKAY);
        rd(6'h14, 32'h0000_3322);
        // Setup while disabled, then a locked peripheral
        wr(6'h04, 4'hf, 32'hffff_ffff, asrb_pkg::RESP_OKAY);
        rd(6'h04, asrb_pkg::MASK_CLOCK_UNIT);
        wr(6'h20, 4'hf, 32'hffff_ffff, asrb_pkg::RESP_OKAY);
        rd(6'h20, asrb_pkg::MASK_SERIALIZER);
        // Serializer 0 now sends: holding writes are synced and collide when close
        wr(6'h30, 4'hf, 32'h0bad_f00d, asrb_pkg::RESP_OKAY);
        wr(6'h30, 4'hf, 32'h1234_5678, asrb_pkg::RESP_SLAVE_ERROR);
        idle();
        rd(6'h30, 32'h0bad_f00d);
        wp_lock_in <= 1'b1;
        wr(6'h04, 4'hf, 32'h0, asrb_pkg::RESP_OKAY);
        rd(6'h04, asrb_pkg::MASK_CLOCK_UNIT);
        wr(6'h00, 4'h1, 32'h0000_0002, asrb_pkg::RESP_OKAY);
        rd(6'h00, 32'h0);
        wp_lock_in <= 1'b0;
        // Enables go through the sync busy window
        wr(6'h00, 4'h1, 32'h0000_003e, asrb_pkg::RESP_OKAY);
        rd(6'h18, 32'h0000_003e);
        idle();
        chk({27'h0, serializer_on_out, clock_unit_on_out, module_on_out}, 32'h1f);
        rd(6'h00, 32'h0000_003e);
        wr(6'h04, 4'hf, 32'h0, asrb_pkg::RESP_OKAY);
        rd(6'h04, asrb_pkg::MASK_CLOCK_UNIT);
        wr(6'h20, 4'hf, 32'h0, asrb_pkg::RESP_OKAY);
        rd(6'h20, asrb_pkg::MASK_SERIALIZER);
        wr(6'h00, 4'h1, 32'h0000_002a, asrb_pkg::RESP_OKAY);
        wr(6'h00, 4'h1, 32'h0000_002a, asrb_pkg::RESP_SLAVE_ERROR);
        idle();
        chk({27'h0, serializer_on_out, clock_unit_on_out, module_on_out}, 32'h15);
        // Back-to-back reads of a receive holding word collide with its sync
        rd(6'h34, 32'h0);
        acc(1'b0, 6'h34, 4'hf, 32'h0);
        chkr(r, asrb_pkg::RESP_SLAVE_ERROR);
        idle();
        // Soft reset wins over the other bits of its write
        wr(6'h00, 4'h1, 32'h0000_003f, asrb_pkg::RESP_OKAY);
        idle();
        rd(6'h00, 32'h0);
        rd(6'h04, 32'h0);
        rd(6'h10, 32'h0);
        rd(6'h30, 32'h0);
        chk({27'h0, serializer_on_out, clock_unit_on_out, module_on_out}, 32'h0);
        give_verdict();
    end
endmodule // asrb_register_bank_test

bind asrb_register_bank asrb_register_bank_assertions #(.SYNC_CYCLES(SYNC_CYCLES))
    u_asrb_register_bank_assertions (.mclk_in(mclk_in), .rst_in(rst_in),
    .avs_address_in(avs_address_in), .avs_byteenable_in(avs_byteenable_in),
    .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
    .avs_writedata_in(avs_writedata_in), .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out), .avs_response_out(avs_response_out),
    .wp_lock_in(wp_lock_in), .irq_event_in(irq_event_in), .module_on_out(module_on_out),
    .clock_unit_on_out(clock_unit_on_out), .serializer_on_out(serializer_on_out),
    .clock_unit_config_out(clock_unit_config_out),
    .serializer_config_out(serializer_config_out), .holding_update_out(holding_update_out),
    .irq_enable_out(irq_enable_out),
    .irq_flags_out(irq_flags_out));
